// *** shared/pulse_scale_pkg.sv ***
package pulse_scale_pkg;

    // ------------------------------------------------------------
    // encoder types and resolutions
    // ------------------------------------------------------------
    localparam logic [1:0]  ENC_13BIT     = 2'h0;
    localparam logic [1:0]  ENC_16BIT     = 2'h1;
    localparam logic [1:0]  ENC_17BIT     = 2'h2;
    localparam logic [16:0] PPR_13BIT     = 17'h00800;
    localparam logic [16:0] PPR_16BIT     = 17'h04000;
    localparam logic [16:0] PPR_17BIT     = 17'h08000;
    localparam int          QUAD_EDGES    = 4;

    // ------------------------------------------------------------
    // setting limits and reset values
    // ------------------------------------------------------------
    localparam logic [16:0] DIV_MIN       = 17'h00010;
    localparam logic [16:0] DIV_MAX       = 17'h04000;
    localparam logic [16:0] DIV_RESET     = 17'h04000;
    localparam logic [15:0] GEAR_NUM_RST  = 16'h0004;
    localparam logic [15:0] GEAR_DEN_RST  = 16'h0001;
    localparam logic [15:0] GEAR_MIN      = 16'h0001;
    localparam int          DIV_STEPS     = 17;
    localparam logic [4:0]  DIV_LAST      = 5'h10;
    localparam int          PEND_W        = 8;
    localparam int          POS_W         = 32;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic step;
        logic fwd;
    } quad_step_t;

    typedef struct packed {
        logic pos;
        logic neg;
    } diff_pair_t;

    // ------------------------------------------------------------
    // quadrature phase helpers: phase a leads b when moving forward
    // ------------------------------------------------------------
    function automatic logic [1:0] ab_to_phase(input logic a, input logic b);
        return {b, a ^ b};
    endfunction

    function automatic logic [1:0] phase_to_ab(input logic [1:0] ph);
        return {ph[1] ^ ph[0], ph[1]};
    endfunction

    function automatic logic [16:0] enc_ppr(input logic [1:0] kind);
        return (kind == ENC_13BIT) ? PPR_13BIT :
               (kind == ENC_16BIT) ? PPR_16BIT : PPR_17BIT;
    endfunction

endpackage

// *** rtl/quad_decoder.sv ***
`timescale 1ns/1ps
module quad_decoder
    import pulse_scale_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       nrst,
    // encoder pins
    input  wire logic       pin_a,
    input  wire logic       pin_b,
    // decoded edges
    output quad_step_t      edge_q,
    output logic            glitch_q
);

    // ------------------------------------------------------------
    // two-stage synchronisers, first stage read only by the second
    // ------------------------------------------------------------
    logic [1:0] meta_q;
    logic [1:0] sync_q;
    logic [1:0] prev_phase_q;
    // the first real sample meets a reset phase, not the pins' own phase:
    // counting waits until both compared phases came from the pins
    logic [2:0] fill_q;
    wire        primed    = fill_q[2];

    wire  [1:0] cur_phase = ab_to_phase(sync_q[1], sync_q[0]);
    wire  [1:0] delta     = cur_phase - prev_phase_q;
    wire        is_fwd    = (delta == 2'h1);
    wire        is_rev    = (delta == 2'h3);
    // both phases moved at once: direction unknown, so no count
    wire        is_skip   = (delta == 2'h2);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            meta_q       <= 2'h0;
            sync_q       <= 2'h0;
            prev_phase_q <= 2'h0;
            fill_q       <= 3'h0;
            edge_q       <= '0;
            glitch_q     <= 1'b0;
        end else begin
            meta_q       <= {pin_a, pin_b};
            sync_q       <= meta_q;
            prev_phase_q <= cur_phase;
            fill_q       <= {fill_q[1:0], 1'b1};
            edge_q.step  <= primed & (is_fwd | is_rev);
            edge_q.fwd   <= is_fwd;
            glitch_q     <= primed & is_skip;
        end
    end

endmodule // quad_decoder

// *** rtl/pulse_scaler.sv ***
`timescale 1ns/1ps
// Summary of operation
// - The divided A/B outputs give as many pulses per revolution as the divider setting, 16 up to a default of 16384.
// - Encoder pulses are scaled by the divider value over the encoder's pulses per revolution before they drive the divided outputs.
// - The usable divider range is 16 to 2048 for a 13-bit encoder and 16 to 16384 for a 16-bit one.
// - With a 13-bit encoder a divider above 2048 is clamped to 2048 pulses per revolution.
// - A new divider setting is only taken at power-up; until then the old one stays.
// - Each reference pulse moves the motor by the electronic gear ratio in encoder counts.
// - The gear numerator is an unsigned 1 to 65535 setting with default 4.
// - The gear denominator is an unsigned 1 to 65535 setting with default 1, ratio being numerator over denominator.
// - Motor counts per revolution are 2048, 16384 or 32768 times four for quadrature.
// - Output pulses per revolution follow the divider, not the encoder bit count.
module pulse_scaler
    import pulse_scale_pkg::*;
(
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              nrst,
    // motor encoder pins
    input  wire logic              motor_encoder_a,
    input  wire logic              motor_encoder_b,
    // host reference pins, sign and pulse
    input  wire logic              ref_pulse,
    input  wire logic              ref_sign,
    // settings
    input  wire logic [1:0]        encoder_type,
    input  wire logic [14:0]       divider_ppr_setting,
    input  wire logic [15:0]       gear_numerator,
    input  wire logic [15:0]       gear_denominator,
    // divided encoder outputs
    output logic                   divided_phase_a_out,
    output logic                   divided_phase_a_out_n,
    output logic                   divided_phase_b_out,
    output logic                   divided_phase_b_out_n,
    // gear result and status
    output logic signed [POS_W-1:0] motor_ref_pos_q,
    output logic                   gear_busy_q,
    output logic                   encoder_glitch_q
);

    // ------------------------------------------------------------
    // encoder input
    // ------------------------------------------------------------
    quad_step_t enc_edge;
    logic       enc_glitch;

    quad_decoder u_enc (
        .core_clk (core_clk),
        .nrst     (nrst),
        .pin_a    (motor_encoder_a),
        .pin_b    (motor_encoder_b),
        .edge_q   (enc_edge),
        .glitch_q (enc_glitch)
    );

    // ------------------------------------------------------------
    // divider setting, captured once after reset release
    // ------------------------------------------------------------
    logic        loaded_q;
    logic [16:0] div_q;
    logic [16:0] ppr_q;

    wire  [16:0] raw_div  = {2'h0, divider_ppr_setting};
    wire  [16:0] ppr_sel  = enc_ppr(encoder_type);
    // the lower of the setting, the absolute maximum and the encoder's own count
    wire  [16:0] div_hi   = (raw_div > DIV_MAX) ? DIV_MAX : raw_div;
    wire  [16:0] div_cap  = (div_hi > ppr_sel) ? ppr_sel : div_hi;
    wire  [16:0] div_lim  = (div_cap < DIV_MIN) ? DIV_MIN : div_cap;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            loaded_q <= 1'b0;
            div_q    <= DIV_RESET;
            ppr_q    <= PPR_16BIT;
        end else if (!loaded_q) begin
            // settings only change at power cycling; later edits are ignored
            loaded_q <= 1'b1;
            div_q    <= div_lim;
            ppr_q    <= ppr_sel;
        end
    end

    // ------------------------------------------------------------
    // pulse divider: fractional accumulator of div/ppr per edge
    // ------------------------------------------------------------
    logic [16:0] frac_q;
    logic [1:0]  out_phase_q;

    wire  [17:0] fsum     = {1'b0, frac_q} + {1'b0, div_q};
    wire         fwd_out  = (fsum >= {1'b0, ppr_q});
    wire  [17:0] fdiff    = {1'b0, frac_q} - {1'b0, div_q};
    wire         rev_out  = fdiff[17];
    wire  [16:0] fwd_frac = fwd_out ? 17'(fsum - {1'b0, ppr_q}) : fsum[16:0];
    wire  [16:0] rev_frac = rev_out ? 17'(fdiff + {1'b0, ppr_q}) : fdiff[16:0];
    wire         take_enc = loaded_q & enc_edge.step;
    wire  [1:0]  out_ab   = phase_to_ab(out_phase_q);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            frac_q      <= 17'h0;
            out_phase_q <= 2'h0;
        end else if (take_enc) begin
            // div never exceeds ppr, so one input edge gives at most one output edge
            if (enc_edge.fwd) begin
                frac_q      <= fwd_frac;
                out_phase_q <= out_phase_q + {1'b0, fwd_out};
            end else begin
                frac_q      <= rev_frac;
                out_phase_q <= out_phase_q - {1'b0, rev_out};
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            divided_phase_a_out   <= 1'b0;
            divided_phase_a_out_n <= 1'b1;
            divided_phase_b_out   <= 1'b0;
            divided_phase_b_out_n <= 1'b1;
            encoder_glitch_q      <= 1'b0;
        end else begin
            divided_phase_a_out   <= out_ab[1];
            divided_phase_a_out_n <= ~out_ab[1];
            divided_phase_b_out   <= out_ab[0];
            divided_phase_b_out_n <= ~out_ab[0];
            encoder_glitch_q      <= enc_glitch;
        end
    end

    // ------------------------------------------------------------
    // host reference pins and pending pulse count
    // ------------------------------------------------------------
    logic [1:0] ref_meta_q;
    logic [1:0] ref_sync_q;
    logic       ref_prev_q;
    logic signed [PEND_W-1:0] pend_q;

    wire ref_rise  = ref_sync_q[1] & ~ref_prev_q;
    wire ref_fwd   = ref_sync_q[0];
    wire pend_zero = (pend_q == '0);

    typedef enum logic [2:0] {
        GS_IDLE   = 3'h1,
        GS_DIVIDE = 3'h2,
        GS_APPLY  = 3'h4
    } gear_state_t;

    gear_state_t gs_q;
    wire take_ref = (gs_q == GS_IDLE) & ~pend_zero;
    wire take_fwd = ~pend_q[PEND_W-1];

    wire signed [PEND_W-1:0] pend_in  = ref_rise ? (ref_fwd ? 8'sh01 : -8'sh01) : 8'sh00;
    wire signed [PEND_W-1:0] pend_out = take_ref ? (take_fwd ? 8'sh01 : -8'sh01) : 8'sh00;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ref_meta_q <= 2'h0;
            ref_sync_q <= 2'h0;
            ref_prev_q <= 1'b0;
            pend_q     <= '0;
        end else begin
            ref_meta_q <= {ref_pulse, ref_sign};
            ref_sync_q <= ref_meta_q;
            ref_prev_q <= ref_sync_q[1];
            // an arriving pulse and a taken one in the same cycle both count
            pend_q     <= pend_q + pend_in - pend_out;
        end
    end

    // ------------------------------------------------------------
    // electronic gear: quotient of (num + rem) / den, 17 steps
    // ------------------------------------------------------------
    logic [15:0] num_q;
    logic [15:0] den_q;
    logic [15:0] rem_q;
    logic        dir_q;
    logic [16:0] dvd_q;
    logic [16:0] quo_q;
    logic [16:0] part_q;
    logic [4:0]  step_q;

    wire  [15:0] num_in   = (gear_numerator == '0) ? GEAR_MIN : gear_numerator;
    wire  [15:0] den_in   = (gear_denominator == '0) ? GEAR_MIN : gear_denominator;
    // reverse pulses work on the mirrored remainder so both ways stay exact
    wire  [15:0] rem_mir  = den_in - GEAR_MIN - rem_q;
    wire  [16:0] dvd_in   = {1'b0, num_in} + {1'b0, take_fwd ? rem_q : rem_mir};
    wire  [17:0] part_sh  = {part_q, dvd_q[16]};
    wire         sub_ok   = (part_sh >= {2'h0, den_q});
    wire  [16:0] part_nx  = sub_ok ? 17'(part_sh - {2'h0, den_q}) : part_sh[16:0];
    wire  [15:0] rem_fwd  = part_q[15:0];
    wire  [15:0] rem_rev  = den_q - GEAR_MIN - part_q[15:0];
    wire signed [POS_W-1:0] quo_ext = {{(POS_W-17){1'b0}}, quo_q};

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            gs_q   <= GS_IDLE;
            num_q  <= GEAR_NUM_RST;
            den_q  <= GEAR_DEN_RST;
            rem_q  <= 16'h0;
            dir_q  <= 1'b0;
            dvd_q  <= 17'h0;
            quo_q  <= 17'h0;
            part_q <= 17'h0;
            step_q <= 5'h0;
        end else begin
            unique case (gs_q)
                GS_IDLE: begin
                    if (take_ref) begin
                        num_q  <= num_in;
                        den_q  <= den_in;
                        dir_q  <= take_fwd;
                        dvd_q  <= dvd_in;
                        part_q <= 17'h0;
                        step_q <= 5'h0;
                        gs_q   <= GS_DIVIDE;
                    end
                end
                GS_DIVIDE: begin
                    part_q <= part_nx;
                    dvd_q  <= {dvd_q[15:0], 1'b0};
                    quo_q  <= {quo_q[15:0], sub_ok};
                    step_q <= step_q + 5'h1;
                    if (step_q == DIV_LAST) begin
                        gs_q <= GS_APPLY;
                    end
                end
                GS_APPLY: begin
                    rem_q <= dir_q ? rem_fwd : rem_rev;
                    gs_q  <= GS_IDLE;
                end
            endcase
        end
    end

    // motor counts are quadrature edges of the encoder, four per line
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            motor_ref_pos_q <= '0;
            gear_busy_q     <= 1'b0;
        end else begin
            gear_busy_q <= ~pend_zero | (gs_q != GS_IDLE);
            if (gs_q == GS_APPLY) begin
                motor_ref_pos_q <= dir_q ? motor_ref_pos_q + quo_ext
                                         : motor_ref_pos_q - quo_ext;
            end
        end
    end

endmodule // pulse_scaler

// *** sim/pulse_scaler_assertions.sv ***
`timescale 1ns/1ps
module pulse_scaler_assertions
    import pulse_scale_pkg::*;
(
    // clock and reset
    input wire logic             core_clk,
    input wire logic             nrst,
    // pins
    input wire logic             motor_encoder_a,
    input wire logic             motor_encoder_b,
    input wire logic             ref_pulse,
    // outputs
    input wire logic             divided_phase_a_out,
    input wire logic             divided_phase_a_out_n,
    input wire logic             divided_phase_b_out,
    input wire logic             divided_phase_b_out_n,
    input wire logic signed [POS_W-1:0] motor_ref_pos_q,
    input wire logic             gear_busy_q
);
    // --------------------------------------------------------
    // helpers
    // --------------------------------------------------------
    // no queueing in our traffic, so a long busy means a stuck divider
    logic [11:0] busy_cnt_q;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) busy_cnt_q <= 12'h000;
        else busy_cnt_q <= gear_busy_q ? busy_cnt_q + 12'h001 : 12'h000;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // --------------------------------------------------------
    // assertions
    // --------------------------------------------------------
    AST_RESET_OUTS: assert property (disable iff (1'b0) !nrst |-> !divided_phase_a_out
        && !divided_phase_b_out && motor_ref_pos_q == 0 && !gear_busy_q)
        else $error("outputs not idle in reset");
    AST_COMPLEMENT: assert property (divided_phase_a_out_n == !divided_phase_a_out
        && divided_phase_b_out_n == !divided_phase_b_out) else $error("pair not complementary");
    AST_QUAD_ONE_STEP: assert property (
        !($changed(divided_phase_a_out) && $changed(divided_phase_b_out)))
        else $error("both output phases moved together");
    AST_OUT_NEEDS_ENC: assert property (($stable(motor_encoder_a)
        && $stable(motor_encoder_b))[*7] |=> $stable({divided_phase_a_out, divided_phase_b_out}))
        else $error("divided output moved without encoder motion");
    AST_POS_NEEDS_BUSY: assert property (
        $changed(motor_ref_pos_q) |-> $past(gear_busy_q))
        else $error("position moved while idle");
    AST_BUSY_AFTER_REF: assert property ($rose(ref_pulse) |-> ##[1:6] gear_busy_q)
        else $error("reference pulse not taken");
    AST_POS_HOLD: assert property (
        $rose(gear_busy_q) |=> $stable(motor_ref_pos_q)[*8])
        else $error("position moved before division ended");
    AST_BUSY_BOUND: assert property (busy_cnt_q < 12'h0c8)
        else $error("gear busy too long");
    COV_GEAR: cover property ($fell(gear_busy_q));
    COV_DIV: cover property ($changed(divided_phase_a_out));
    COV_NEG: cover property ($changed(motor_ref_pos_q) && motor_ref_pos_q[POS_W-1]);
endmodule // pulse_scaler_assertions

bind pulse_scaler pulse_scaler_assertions chk (.core_clk(core_clk), .nrst(nrst),
    .motor_encoder_a(motor_encoder_a), .motor_encoder_b(motor_encoder_b),
    .ref_pulse(ref_pulse), .divided_phase_a_out(divided_phase_a_out),
    .divided_phase_a_out_n(divided_phase_a_out_n), .divided_phase_b_out(divided_phase_b_out),
    .divided_phase_b_out_n(divided_phase_b_out_n), .motor_ref_pos_q(motor_ref_pos_q),
    .gear_busy_q(gear_busy_q));

// *** sim/host_ref_gen.sv ***
`timescale 1ns/1ps
module host_ref_gen (
    // clock
    input wire logic core_clk,
    // reference pins
    output logic     ref_pulse,
    output logic     ref_sign
);
    initial begin
        ref_pulse = 1'b0;
        ref_sign = 1'b1;
    end
    // one pulse per reference unit; 80 cycle period keeps within 500 kpps
    task automatic send(input int n, input logic fwd);
        if (ref_sign !== fwd) begin
            ref_sign = fwd;
            repeat (120) @(negedge core_clk);
        end
        for (int i = 0; i < n; i++) begin
            ref_pulse = 1'b1;
            repeat (40) @(negedge core_clk);
            ref_pulse = 1'b0;
            repeat (40) @(negedge core_clk);
        end
    endtask
endmodule // host_ref_gen

// *** sim/pulse_scaler_test.sv ***
`timescale 1ns/1ps
module pulse_scaler_test;
    import pulse_scale_pkg::*;
    logic core_clk, nrst, motor_encoder_a, motor_encoder_b, ref_pulse, ref_sign;
    logic [1:0]  encoder_type;
    logic [14:0] divider_ppr_setting;
    logic [15:0] gear_numerator, gear_denominator;
    logic a_o, a_n, b_o, b_n, gear_busy_q, glitch, glitch_seen;
    logic signed [POS_W-1:0] motor_ref_pos_q;
    logic [1:0]  enc_ph, ab_prev;
    longint      out_edges, num, den, g, nf, nr, exp_n;
    int          bad_count, compares;
    logic [1:0]  enc_tab [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h1};
    logic [14:0] set_tab [6] = '{15'h0064, 15'h0bb8, 15'h4000, 15'h1000, 15'h4000, 15'h000a};

    pulse_scaler uut (.core_clk(core_clk), .nrst(nrst), .motor_encoder_a(motor_encoder_a),
        .motor_encoder_b(motor_encoder_b), .ref_pulse(ref_pulse), .ref_sign(ref_sign),
        .encoder_type(encoder_type), .divider_ppr_setting(divider_ppr_setting),
        .gear_numerator(gear_numerator), .gear_denominator(gear_denominator),
        .divided_phase_a_out(a_o), .divided_phase_a_out_n(a_n), .divided_phase_b_out(b_o),
        .divided_phase_b_out_n(b_n), .motor_ref_pos_q(motor_ref_pos_q),
        .gear_busy_q(gear_busy_q), .encoder_glitch_q(glitch));
    host_ref_gen host (.core_clk(core_clk), .ref_pulse(ref_pulse), .ref_sign(ref_sign));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (!nrst) out_edges <= 0;
        else if ({a_o, b_o} !== ab_prev) out_edges <= out_edges + 1;
        ab_prev <= {a_o, b_o};
        // the glitch flag stands one cycle only, so it is latched here
        if (!nrst) glitch_seen <= 1'b0;
        else if (glitch === 1'b1) glitch_seen <= 1'b1;
    end
    task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    function automatic longint exp_edges(logic [1:0] enc, logic [14:0] set, longint e);
        longint ppr, eff;
        ppr = (enc == 2'h0) ? 2048 : (enc == 2'h1) ? 16384 : 32768;
        eff = (set < 16) ? 16 : set;
        eff = (eff > ppr) ? ppr : eff;
        eff = (eff > 16384) ? 16384 : eff;
        return e * eff / ppr;
    endfunction
    function automatic longint gear_floor(longint n, longint nu, longint de);
        longint p, q;
        p = n * nu;
        q = p / de;
        if (p < 0 && p % de != 0) q--;
        return q;
    endfunction
    function automatic longint gcd(longint x, longint y);
        return (y == 0) ? x : gcd(y, x % y);
    endfunction
    // encoder pins step, A leads B going forward; 4 cycles apart for the synchroniser
    task automatic enc_steps(int n, logic fwd);
        for (int i = 0; i < n; i++) begin
            enc_ph = fwd ? enc_ph + 2'h1 : enc_ph - 2'h1;
            motor_encoder_a = enc_ph[1] ^ enc_ph[0];
            motor_encoder_b = enc_ph[1];
            repeat (4) @(negedge core_clk);
        end
    endtask
    task automatic do_reset();
        nrst = 1'b0;
        repeat (6) @(negedge core_clk);
        check("reset_outs", {a_o, a_n, b_o, b_n, gear_busy_q}, 5'h0a);
        check("reset_pos", 64'(motor_ref_pos_q), 64'h0);
        nrst = 1'b1;
        repeat (2) @(negedge core_clk);
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (95000) @(posedge core_clk);
        bad_count++;
        end_sim();
    end
    initial begin
        {nrst, motor_encoder_a, motor_encoder_b, enc_ph} = 5'h00;
        {encoder_type, divider_ppr_setting} = {2'h0, 15'h4000};
        {gear_numerator, gear_denominator} = {16'h0004, 16'h0001};
        bad_count = 0;
        compares = 0;
        void'($urandom(32'hf893));
        @(negedge core_clk);
        for (int t = 0; t < 6; t++) begin
            encoder_type = enc_tab[t];
            divider_ppr_setting = set_tab[t];
            do_reset();
            // a late change must not be picked up without a reset
            divider_ppr_setting = 15'($urandom);
            enc_steps(2049, 1'b1);
            repeat (10) @(negedge core_clk);
            exp_n = exp_edges(enc_tab[t], set_tab[t], 2049);
            check("div_edges", out_edges, exp_n);
            check("glitch", glitch_seen, 1'b0);
            if (t == 0) begin
                // retraced steps undo exactly the overflows they once made
                enc_steps(1025, 1'b0);
                repeat (10) @(negedge core_clk);
                exp_n = 2 * exp_n - exp_edges(enc_tab[t], set_tab[t], 1024);
                check("rev_edges", out_edges, exp_n);
            end
            // a jump of two phases has no direction: flagged, never counted
            enc_ph = enc_ph + 2'h2;
            motor_encoder_a = enc_ph[1] ^ enc_ph[0];
            motor_encoder_b = enc_ph[1];
            repeat (10) @(negedge core_clk);
            check("jump_glitch", glitch_seen, 1'b1);
            check("jump_edges", out_edges, exp_n);
        end
        for (int i = 0; i < 5; i++) begin
            case (i)
                0: {num, den} = {64'd4, 64'd1};
                1: {num, den} = {64'd1, 64'd100};
                2: {num, den} = {64'd100, 64'd1};
                default: begin
                    num = $urandom_range(6000, 1);
                    den = (num * 100 > 65534) ? 65534 : num * 100;
                    den = $urandom_range(int'(den), int'((num + 99) / 100));
                end
            endcase
            g = gcd(num, den);
            gear_numerator = 16'(num / g);
            gear_denominator = 16'(den / g);
            do_reset();
            nf = $urandom_range(30, 1);
            nr = $urandom_range(40, 0);
            host.send(int'(nf), 1'b1);
            host.send(int'(nr), 1'b0);
            repeat (40) @(negedge core_clk);
            for (int k = 0; k < 500 && gear_busy_q !== 1'b0; k++) @(negedge core_clk);
            check("busy_end", gear_busy_q, 1'b0);
            exp_n = gear_floor(nf - nr, num / g, den / g);
            check("pos", 64'(motor_ref_pos_q), 64'(exp_n));
        end
        end_sim();
    end
endmodule // pulse_scaler_test
